// ==== dtcc_pkg.sv ====
package dtcc_pkg;
	// widths of the internal bus and the channel state
	localparam int AW         = 20;
	localparam int DW         = 16;
	localparam int CW         = 16;
	localparam int NCH        = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int CTLW       = 5;

	// register byte offsets; channel one adds the stride
	localparam logic [5:0] OFF_SRC   = 6'h00;
	localparam logic [5:0] OFF_DST   = 6'h04;
	localparam logic [5:0] OFF_RLD   = 6'h08;
	localparam logic [5:0] OFF_CTL   = 6'h0C;
	localparam logic [5:0] CH_STRIDE = 6'h10;
	localparam logic [5:0] OFF_STAT  = 6'h20;
	localparam logic [5:0] OFF_CNT   = 6'h24;

	// control and status field positions
	localparam int CTL_EN     = 0;
	localparam int CTL_UNIT8  = 1;
	localparam int CTL_FWDSRC = 2;
	localparam int CTL_SWAIT  = 3;
	localparam int CTL_DWAIT  = 4;
	localparam int STAT_ACT   = 0;
	localparam int STAT_PEND  = 2;

	// special_function_register_area lies below this address
	localparam logic [AW-1:0] SPECIAL_LIMIT = 20'h00400;
	localparam logic [1:0]    BE_WORD   = 2'h3;
	localparam logic [1:0]    BE_HI     = 2'h2;
	localparam logic [1:0]    BE_LO     = 2'h1;
	localparam logic [AW-1:0] STEP_BYTE = 20'h00001;
	localparam logic [AW-1:0] STEP_WORD = 20'h00002;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ARB   = 3'h1,
		ST_READ  = 3'h3,
		ST_FILL  = 3'h2,
		ST_WRITE = 3'h6,
		ST_YIELD = 3'h7
	} dtcc_st_e;

	// one internal bus cycle as driven by the engine
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [1:0]    be;
		logic          rd;
		logic          wr;
		logic [DW-1:0] wdata;
	} dtcc_mbus_s;
endpackage

// ==== dtcc_fifo.sv ====
`timescale 1ns/1ps
module dtcc_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);
	import dtcc_pkg::*;
	localparam int PW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW:0]         wp;
		logic [PW:0]         rp;
	} dtcc_fifo_s;

	dtcc_fifo_s r;
	dtcc_fifo_s n;

	// full when pointers differ only in the wrap bit
	assign in_ready  = !((r.wp[PW] != r.rp[PW]) &&
		(r.wp[PW-1:0] == r.rp[PW-1:0]));
	assign out_valid = (r.wp != r.rp);
	assign out_data  = r.mem[r.rp[PW-1:0]];

	// push and pop
	always_comb begin
		n = r;
		if (in_valid && in_ready) begin
			n.mem[r.wp[PW-1:0]] = in_data;
			n.wp = r.wp + 1'b1;
		end
		if (out_ready && out_valid) begin
			n.rp = r.rp + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

// ==== dtcc_chan.sv ====
`timescale 1ns/1ps
module dtcc_chan #(
	parameter int AW = dtcc_pkg::AW,
	parameter int CW = dtcc_pkg::CW
) (
	input  wire logic          clock,
	input  wire logic          nrst,
	input  wire logic          load,
	input  wire logic          adv,
	input  wire logic          unit8,
	input  wire logic [AW-1:0] ld_ptr,
	input  wire logic [CW-1:0] ld_cnt,
	output logic      [AW-1:0] ptr,
	output logic      [CW-1:0] cnt
);
	import dtcc_pkg::*;

	typedef struct packed {
		logic [AW-1:0] ptr;
		logic [CW-1:0] cnt;
	} dtcc_chan_s;

	dtcc_chan_s r;
	dtcc_chan_s n;

	assign ptr = r.ptr;
	assign cnt = r.cnt;

	// reload on the first transfer, step after each unit
	always_comb begin
		n = r;
		if (load) begin
			n.ptr = ld_ptr;
			n.cnt = ld_cnt;
		end else if (adv) begin
			n.ptr = r.ptr + (unit8 ? STEP_BYTE : STEP_WORD);
			n.cnt = r.cnt - CW'(1);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

// ==== dtcc_top.sv ====
`timescale 1ns/1ps
// What this block does
// RULE1: each unit is source read bus cycles, then destination write cycles
// RULE2: outside single-chip mode the width pin also sets cycle counts
// RULE3: 16-bit unit, 16-bit bus, odd start adds one read and one write; code: one read for odd source, one write for odd destination
// RULE4: special area or waited memory costs one extra clock per access
// RULE5: every bus cycle is timed in clocks of the bus clock
// RULE6: write cycles follow the same alignment, width and wait terms
// RULE7: 16-bit unit over an 8-bit bus takes two reads and two writes
// RULE8: any mix of even and odd source and destination works
// RULE9: unit bit 1 means byte units, 0 means 16-bit units
// RULE10: clocks per unit are reads times j plus writes times k
// RULE11: writing 1 to the enable bit activates the channel
// RULE12: first transfer loads the forward pointer from source or destination
// RULE13: first transfer loads the counter from its reload value
// RULE14: enable written again while active repeats both reloads
// RULE15: pending flag clears just before that channel's transfer
// RULE16: channel zero first; bus yields to one processor access after units
// RULE17: each finished unit steps the pointer and decrements the counter
module dtcc_top #(
	parameter int CW = dtcc_pkg::CW,
	parameter int FD = dtcc_pkg::FIFO_DEPTH
) (
	input  wire logic                    clock,
	input  wire logic                    nrst,
	input  wire logic [5:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic      [31:0]             avs_readdata,
	output logic                         avs_waitrequest,
	input  wire logic                    single_chip,
	input  wire logic                    byte_pin,
	input  wire logic [dtcc_pkg::NCH-1:0] dma_req,
	input  wire logic                    cpu_done,
	input  wire logic [dtcc_pkg::DW-1:0] mbus_rdata,
	output dtcc_pkg::dtcc_mbus_s         mbus,
	output logic                         bus_hold
);
	import dtcc_pkg::*;

	typedef struct packed {
		logic [NCH-1:0][AW-1:0]   src;
		logic [NCH-1:0][AW-1:0]   dst;
		logic [NCH-1:0][CW-1:0]   rld;
		logic [NCH-1:0][CTLW-1:0] ctl;
		logic [NCH-1:0]           pend;
		logic [NCH-1:0]           act;
		logic [NCH-1:0]           first;
		dtcc_st_e                 st;
		logic                     ch;
		logic                     cyc;
		logic                     wcnt;
		logic                     rtwo;
		logic                     wtwo;
		logic                     rwt;
		logic                     wwt;
		logic                     unit8;
		logic [AW-1:0]            sa;
		logic [AW-1:0]            da;
		logic [DW-1:0]            ubuf;
		dtcc_mbus_s               mbus;
		logic                     hold;
		logic                     wreq;
		logic [31:0]              rdata;
	} dtcc_top_s;

	dtcc_top_s              r;
	dtcc_top_s              n;
	logic [NCH-1:0]         rdy;
	logic [NCH-1:0]         clr;
	logic [NCH-1:0]         load;
	logic [NCH-1:0]         adv;
	logic [NCH-1:0]         en_wr;
	logic [NCH-1:0][AW-1:0] ptr;
	logic [NCH-1:0][CW-1:0] cnt;
	logic                   gnt;
	logic                   bus8;
	logic                   cha;
	logic                   acc;
	logic                   take;
	logic                   pop;
	logic                   fifo_in_ready;
	logic                   fifo_out_valid;
	logic [DW-1:0]          fifo_out;
	logic [AW-1:0]          ld_ptr;
	logic [CW-1:0]          ld_cnt;
	logic [AW-1:0]          fwd;
	logic [AW-1:0]          sa;
	logic [AW-1:0]          da;
	logic [7:0]             lane;
	logic [5:0]             roff;
	logic [31:0]            wm;
	logic [31:0]            nc;
	logic [31:0]            rd_mux;

	assign avs_readdata    = r.rdata;
	assign avs_waitrequest = r.wreq;
	assign mbus            = r.mbus;
	assign bus_hold        = r.hold;

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(logic [31:0] o,
		logic [31:0] d, logic [31:0] m);
		return (o & ~m) | (d & m);
	endfunction

	// one bus cycle: word when full, else one byte on its lane
	function automatic dtcc_mbus_s cyc_of(logic [AW-1:0] a, logic k,
		logic full, logic [DW-1:0] d, logic wr);
		dtcc_mbus_s m;
		m.addr  = a + AW'(k);
		m.be    = full ? BE_WORD : (m.addr[0] ? BE_HI : BE_LO);
		m.rd    = !wr;
		m.wr    = wr;
		m.wdata = full ? d : {2{d[k*8 +: 8]}};
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////
	// channel pointer and counter units
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		dtcc_chan #(
			.AW (AW),
			.CW (CW)
		) u_chan (
			.clock  (clock),
			.nrst   (nrst),
			.load   (load[g]),
			.adv    (adv[g]),
			.unit8  (r.unit8),
			.ld_ptr (ld_ptr),
			.ld_cnt (ld_cnt),
			.ptr    (ptr[g]),
			.cnt    (cnt[g])
		);
	end

	// unit buffer between the read and write phases
	dtcc_fifo #(
		.W (DW),
		.D (FD)
	) u_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (r.st == ST_FILL),
		.in_data   (r.ubuf),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out),
		.out_ready (pop)
	);

	////////////////////////////////////////////////////////////////////
	// operand selection for the channel about to be granted
	assign bus8   = !single_chip && byte_pin; // RULE2
	assign rdy    = r.act & r.pend;
	assign gnt    = !rdy[0]; // RULE16
	assign ld_ptr = r.ctl[gnt][CTL_FWDSRC] ? r.src[gnt] : r.dst[gnt];
	assign ld_cnt = r.rld[gnt];
	assign fwd    = r.first[gnt] ? ld_ptr : ptr[gnt];
	assign sa     = r.ctl[gnt][CTL_FWDSRC] ? fwd : r.src[gnt];
	assign da     = r.ctl[gnt][CTL_FWDSRC] ? r.dst[gnt] : fwd;
	assign lane   = r.mbus.addr[0] ? mbus_rdata[15:8] : mbus_rdata[7:0];

	// register decode; bit 4 picks the channel
	assign roff = avs_address & ~CH_STRIDE;
	assign cha  = |(avs_address & CH_STRIDE);
	assign acc  = (avs_read || avs_write) && r.wreq;
	assign take = (avs_read || avs_write) && !r.wreq;
	assign wm   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign nc   = merge(32'(r.ctl[cha]), avs_writedata, wm);

	// read multiplexer, unmapped reads return zero
	always_comb begin
		rd_mux = '0;
		case (roff)
			OFF_SRC: rd_mux = 32'(r.src[cha]);
			OFF_DST: rd_mux = 32'(r.dst[cha]);
			OFF_RLD: rd_mux = 32'(r.rld[cha]);
			OFF_CTL: rd_mux = 32'({r.ctl[cha][CTLW-1:1], r.act[cha]});
			OFF_CNT: rd_mux = 32'(cnt[cha]);
			OFF_STAT: begin
				if (!cha) begin
					rd_mux[STAT_ACT +: NCH]  = r.act;
					rd_mux[STAT_PEND +: NCH] = r.pend;
				end
			end
			default: rd_mux = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// sequencer, bus slave and request flags
	always_comb begin
		n     = r;
		clr   = '0;
		load  = '0;
		adv   = '0;
		en_wr = '0;
		pop   = 1'b0;
		n.wreq = !acc;
		if (acc && avs_read) begin
			n.rdata = rd_mux;
		end
		case (r.st)
			ST_IDLE: begin
				if (|rdy) begin
					n.st = ST_ARB;
				end
			end
			ST_ARB: begin
				if (rdy == '0) begin
					n.st = ST_IDLE;
				end else begin
					clr[gnt]     = 1'b1; // RULE15
					load[gnt]    = r.first[gnt]; // RULE12 RULE13
					n.first[gnt] = 1'b0;
					n.ch    = gnt; // RULE16
					n.hold  = 1'b1;
					n.unit8 = r.ctl[gnt][CTL_UNIT8]; // RULE9
					n.sa    = sa;
					n.da    = da;
					n.rtwo  = !n.unit8 && (bus8 || sa[0]); // RULE3 RULE7
					n.wtwo  = !n.unit8 && (bus8 || da[0]); // RULE6 RULE8
					n.rwt   = r.ctl[gnt][CTL_SWAIT] || (sa < SPECIAL_LIMIT); // RULE4
					n.wwt   = r.ctl[gnt][CTL_DWAIT] || (da < SPECIAL_LIMIT); // RULE6
					n.cyc   = 1'b0;
					n.wcnt  = n.rwt; // RULE10
					n.mbus  = cyc_of(sa, 1'b0, !n.rtwo && !n.unit8, '0,
						1'b0); // RULE1
					n.st    = ST_READ;
				end
			end
			ST_READ: begin
				if (r.wcnt) begin
					n.wcnt = 1'b0; // RULE5
				end else begin
					if (!r.rtwo && !r.unit8) begin
						n.ubuf = mbus_rdata;
					end else if (r.cyc) begin
						n.ubuf[15:8] = lane;
					end else begin
						n.ubuf[7:0] = lane;
					end
					if (r.rtwo && !r.cyc) begin
						n.cyc  = 1'b1;
						n.wcnt = r.rwt;
						n.mbus = cyc_of(r.sa, 1'b1, 1'b0, '0, 1'b0);
					end else begin
						n.mbus.rd = 1'b0;
						n.st      = ST_FILL;
					end
				end
			end
			ST_FILL: begin
				if (fifo_in_ready) begin
					n.cyc = 1'b0;
					n.st  = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (!r.mbus.wr) begin
					if (fifo_out_valid) begin
						n.mbus = cyc_of(r.da, 1'b0, !r.wtwo && !r.unit8,
							fifo_out, 1'b1); // RULE1
						n.wcnt = r.wwt; // RULE6
					end
				end else if (r.wcnt) begin
					n.wcnt = 1'b0;
				end else if (r.wtwo && !r.cyc) begin
					n.cyc  = 1'b1;
					n.wcnt = r.wwt;
					n.mbus = cyc_of(r.da, 1'b1, 1'b0, fifo_out, 1'b1);
				end else begin
					n.mbus.wr = 1'b0;
					pop       = 1'b1;
					adv[r.ch] = 1'b1; // RULE17
					n.hold    = 1'b0;
					n.st      = ST_YIELD;
					if (cnt[r.ch] == '0) begin
						n.act[r.ch] = 1'b0;
					end
				end
			end
			ST_YIELD: begin
				if (cpu_done) begin
					n.st = ST_IDLE; // RULE16
				end
			end
			default: n.st = ST_IDLE;
		endcase
		// register writes take effect at the edge that ends the wait
		if (take && avs_write) begin
			case (roff)
				OFF_SRC: n.src[cha] = AW'(merge(32'(r.src[cha]),
					avs_writedata, wm));
				OFF_DST: n.dst[cha] = AW'(merge(32'(r.dst[cha]),
					avs_writedata, wm));
				OFF_RLD: n.rld[cha] = CW'(merge(32'(r.rld[cha]),
					avs_writedata, wm));
				OFF_CTL: begin
					n.ctl[cha] = nc[CTLW-1:0];
					n.act[cha] = nc[CTL_EN]; // RULE11
					if (nc[CTL_EN]) begin
						n.first[cha] = 1'b1; // RULE14
						en_wr[cha]   = 1'b1;
					end
				end
				OFF_STAT: begin
					if (!cha && avs_byteenable[0]) begin
						clr = clr | ~avs_writedata[STAT_PEND +: NCH];
					end
				end
				default: n.rdata = r.rdata;
			endcase
		end
		// a request in the clearing cycle survives
		n.pend = (r.pend & ~clr) | dma_req;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			r      <= '0;
			r.wreq <= 1'b1;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////
	// per-unit bus cycle counters watched by the checks below
	logic [1:0] nrd;
	logic [1:0] nwr;
	logic [3:0] ucyc;
	logic [3:0] uexp;

	assign uexp = {2'b00, r.rtwo, !r.rtwo} * {2'b00, r.rwt, !r.rwt} +
		{2'b00, r.wtwo, !r.wtwo} * {2'b00, r.wwt, !r.wwt};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			nrd  <= '0;
			nwr  <= '0;
			ucyc <= '0;
		end else if (r.st == ST_ARB) begin
			nrd  <= '0;
			nwr  <= '0;
			ucyc <= '0;
		end else begin
			if (r.mbus.rd && !r.wcnt) begin
				nrd <= nrd + 2'd1;
			end
			if (r.mbus.wr && !r.wcnt) begin
				nwr <= nwr + 2'd1;
			end
			if (r.mbus.rd || r.mbus.wr) begin
				ucyc <= ucyc + 4'd1;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_grant;
		r.st == ST_ARB && (rdy != '0);
	endsequence

	sequence s_unit_end;
		r.st == ST_WRITE && r.mbus.wr && !r.wcnt && !(r.wtwo && !r.cyc);
	endsequence

	sequence s_special_cycle;
		r.mbus.rd && r.wcnt ##1 r.mbus.rd && !r.wcnt;
	endsequence

	read_first_a: // RULE1
	assert property ($rose(r.mbus.wr) |-> nrd != 2'd0 && !r.mbus.rd)
		else $error("write cycle without a preceding read");

	odd_extra_a: // RULE3
	assert property (r.st == ST_FILL && !r.unit8 && r.sa[0]
		|-> nrd == 2'd2)
		else $error("odd 16-bit unit did not take two reads");

	narrow_bus_a: // RULE7
	assert property (r.st == ST_FILL && !r.unit8 && bus8 |-> nrd == 2'd2)
		else $error("16-bit unit on 8-bit bus did not take two reads");

	single_read_a: // RULE9
	assert property (r.st == ST_FILL && !bus8 && (r.unit8 || !r.sa[0])
		|-> nrd == 2'd1)
		else $error("byte or even unit took more than one read");

	write_match_a: // RULE6
	assert property (r.st == ST_YIELD && $past(r.st) == ST_WRITE
		|-> nwr == (r.wtwo ? 2'd2 : 2'd1))
		else $error("write cycle count differs from its terms");

	wait_stretch_a: // RULE4
	assert property ($rose(r.mbus.rd) && r.mbus.addr < SPECIAL_LIMIT
		|-> s_special_cycle)
		else $error("special area read not stretched by one clock");

	unit_clocks_a: // RULE10
	assert property (s_unit_end |=> ucyc == uexp)
		else $error("clocks per unit differ from reads*j + writes*k");

	pend_clear_a: // RULE15
	assert property (s_grant and (dma_req == '0) |=> !r.pend[r.ch])
		else $error("pending flag not cleared at transfer start");

	prio_a: // RULE16
	assert property (s_grant and rdy[0] |=> !r.ch && r.hold)
		else $error("channel zero not served first");

	yield_a: // RULE16
	assert property (r.st == ST_YIELD && !cpu_done
		|=> r.st == ST_YIELD && !r.hold)
		else $error("bus taken again before a processor access");

	enable_a: // RULE11 RULE14
	assert property (en_wr[0] |=> r.act[0] && r.first[0])
		else $error("enable write did not arm channel zero");

	reload_a: // RULE12 RULE13
	assert property (s_grant and r.first[gnt]
		|=> ptr[r.ch] == $past(ld_ptr) && cnt[r.ch] == $past(ld_cnt))
		else $error("first transfer did not reload pointer and counter");

	advance_a: // RULE17
	assert property (s_unit_end |=> cnt[r.ch] == $past(cnt[r.ch]) - CW'(1))
		else $error("counter not decremented after a unit");
endmodule

// ==== dtcc_mem_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// behavioural internal memory and special area on the engine's bus
module dtcc_mem_model (
	input  wire logic                 clock,
	input  wire dtcc_pkg::dtcc_mbus_s mbus,
	output logic      [15:0]          rdata
);
	import dtcc_pkg::*;
	logic [7:0]  mem [0:4095];
	logic [15:0] last;
	logic [11:0] wa;

	////////////////////////////////////////////////////////////////////
	// preload a byte pattern so that every copied byte is recognisable
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i ^ (i >> 4));
		end
		last = 16'h0000;
	end

	// word address; byte lanes pick the half
	assign wa = {mbus.addr[11:1], 1'b0};
	// answers while rd is held; a released bus shows the inverse word
	assign rdata = mbus.rd ? {mem[wa + 12'h001], mem[wa]} : ~last;

	// write lanes by byte enable, remember the last word driven
	always @(posedge clock) begin
		if (mbus.rd) begin
			last <= rdata;
		end
		if (mbus.wr && mbus.be[0]) begin
			mem[wa] <= mbus.wdata[7:0];
		end
		if (mbus.wr && mbus.be[1]) begin
			mem[wa + 12'h001] <= mbus.wdata[15:8];
		end
	end
endmodule

// ==== dtcc_top_bench.sv ====
`timescale 1ns/1ps
module dtcc_top_bench;
	import dtcc_pkg::*;
	logic             clock, nrst, avs_read, avs_write, single_chip;
	logic             byte_pin, cpu_done, bus_hold, avs_waitrequest;
	logic [5:0]       avs_address;
	logic [31:0]      avs_writedata, avs_readdata, rd_v;
	logic [3:0]       avs_byteenable;
	logic [NCH-1:0]   dma_req;
	logic [DW-1:0]    mbus_rdata;
	dtcc_mbus_s       mbus;
	int               n_mismatch, cmp_count, cycles;

	////////////////////////////////////////////////////////////////////
	// design and far-side memory
	dtcc_top u_dtcc_top (.clock(clock), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .single_chip(single_chip),
		.byte_pin(byte_pin), .dma_req(dma_req), .cpu_done(cpu_done),
		.mbus_rdata(mbus_rdata), .mbus(mbus), .bus_hold(bus_hold));
	dtcc_mem_model u_dtcc_mem_model (.clock(clock), .mbus(mbus),
		.rdata(mbus_rdata));

	// 100 MHz clock
	always #5 clock = ~clock;

	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one Avalon transfer; held until waitrequest is sampled low
	task av(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		// look at the settled outputs mid-cycle, act on the next edge
		do begin
			@(negedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd_v = avs_readdata;
		@(posedge clock);
		chk(32'(n < 20), 32'h1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task rd_chk(input logic [5:0] a, input logic [31:0] exp);
		av(1'b0, a, 32'h0);
		chk(rd_v, exp);
	endtask

	task setup(input int ch, input logic [19:0] s, input logic [19:0] d,
		input logic [15:0] r, input logic [4:0] c);
		logic [5:0] b;
		b = (ch != 0) ? CH_STRIDE : 6'h00;
		av(1'b1, b + OFF_SRC, 32'(s));
		av(1'b1, b + OFF_DST, 32'(d));
		av(1'b1, b + OFF_RLD, 32'(r));
		av(1'b1, b + OFF_CTL, 32'(c));
	endtask

	task req_pulse(input logic [1:0] m);
		@(posedge clock);
		dma_req <= m;
		@(posedge clock);
		dma_req <= 2'h0;
	endtask

	task pulse_done;
		@(posedge clock);
		cpu_done <= 1'b1;
		@(posedge clock);
		cpu_done <= 1'b0;
	endtask

	// one unit: count read and write clocks, note first addresses
	task unit(input logic [1:0] req, input logic [19:0] es,
		input logic [19:0] ed, input int nr, input int nw,
		input logic done);
		int rc, wc, n;
		logic [19:0] fs, fd;
		logic seen;
		rc = 0;
		wc = 0;
		n = 0;
		seen = 1'b0;
		fs = 20'hFFFFF;
		fd = 20'hFFFFF;
		if (req != 2'h0) begin
			req_pulse(req);
		end
		while (n < 80 && !(seen && bus_hold === 1'b0)) begin
			@(negedge clock);
			n++;
			if (bus_hold === 1'b1) begin
				seen = 1'b1;
			end
			if (mbus.rd === 1'b1) begin
				if (rc == 0) fs = mbus.addr;
				rc++;
			end
			if (mbus.wr === 1'b1) begin
				if (wc == 0) fd = mbus.addr;
				wc++;
			end
		end
		chk(32'(rc), 32'(nr));
		chk(32'(wc), 32'(nw));
		chk(32'(fs), 32'(es));
		chk(32'(fd), 32'(ed));
		if (done) pulse_done();
	endtask

	function automatic logic [7:0] pat(input logic [11:0] a);
		return a[7:0] ^ a[11:4];
	endfunction

	task data_ok(input logic [19:0] s, input logic [19:0] d, input int nb);
		for (int i = 0; i < nb; i++) begin
			chk(32'(u_dtcc_mem_model.mem[12'(d + i)]),
				32'(pat(12'(s + i))));
		end
	endtask

	// channel zero case: first unit, data, optional second unit
	task run_case(input logic [19:0] s, input logic [19:0] d,
		input logic [15:0] r, input logic [4:0] c, input int nr,
		input int nw, input int nb, input logic [19:0] s2,
		input logic [19:0] d2);
		setup(0, s, d, r, c);
		unit(2'h1, s, d, nr, nw, 1'b1);
		data_ok(s, d, nb);
		if (r != 16'h0) begin
			rd_chk(OFF_CNT, 32'h0);
			unit(2'h1, s2, d2, nr, nw, 1'b1);
		end
		rd_chk(OFF_STAT, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		single_chip = 1'b1;
		byte_pin = 1'b1;
		dma_req = 2'h0;
		cpu_done = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (16) @(posedge clock);
		chk(32'(avs_waitrequest), 32'h1);
		chk(32'({bus_hold, mbus.rd, mbus.wr}), 32'h0);
		nrst <= 1'b1;
		rd_chk(OFF_STAT, 32'h0);
		rd_chk(OFF_CNT, 32'h0);
		av(1'b1, 6'h38, 32'hFFFFFFFF);
		rd_chk(6'h38, 32'h0);
		// partial write: only byte lane 0 of the reload value changes
		avs_byteenable <= 4'h1;
		av(1'b1, OFF_RLD, 32'hFFFFFFFF);
		avs_byteenable <= 4'hF;
		rd_chk(OFF_RLD, 32'h000000FF);
		// single-chip cases; width pin is ignored there
		run_case(20'h00800, 20'h00900, 16'h1, 5'h05,
			1, 1, 2, 20'h00802, 20'h00900);
		run_case(20'h00881, 20'h00981, 16'h0, 5'h05,
			2, 2, 2, 20'h0, 20'h0);
		run_case(20'h008A1, 20'h009A0, 16'h0, 5'h07,
			1, 1, 1, 20'h0, 20'h0);
		run_case(20'h008B0, 20'h009B0, 16'h0, 5'h0D,
			2, 1, 2, 20'h0, 20'h0);
		run_case(20'h008C0, 20'h00300, 16'h0, 5'h05,
			1, 2, 2, 20'h0, 20'h0);
		run_case(20'h00380, 20'h009F0, 16'h0, 5'h05,
			2, 1, 2, 20'h0, 20'h0);
		run_case(20'h008E0, 20'h009E0, 16'h1, 5'h11,
			1, 2, 2, 20'h008E0, 20'h009E2);
		// expansion mode with an 8-bit external bus
		single_chip <= 1'b0;
		run_case(20'h008D0, 20'h009D0, 16'h0, 5'h05,
			2, 2, 2, 20'h0, 20'h0);
		single_chip <= 1'b1;
		// enable rewritten while active restarts pointer and count
		setup(0, 20'h00A00, 20'h00B00, 16'h2, 5'h05);
		unit(2'h1, 20'h00A00, 20'h00B00, 1, 1, 1'b1);
		rd_chk(OFF_CNT, 32'h1);
		av(1'b1, OFF_CTL, 32'h5);
		unit(2'h1, 20'h00A00, 20'h00B00, 1, 1, 1'b1);
		rd_chk(OFF_CNT, 32'h1);
		av(1'b1, OFF_CTL, 32'h0);
		// pending flag on an idle channel, cleared by software
		req_pulse(2'h2);
		rd_chk(OFF_STAT, 32'h8);
		av(1'b1, OFF_STAT, 32'h0);
		rd_chk(OFF_STAT, 32'h0);
		req_pulse(2'h2);
		setup(1, 20'h00C00, 20'h00D00, 16'h0, 5'h05);
		unit(2'h0, 20'h00C00, 20'h00D00, 1, 1, 1'b1);
		rd_chk(OFF_STAT, 32'h0);
		// both channels at once: zero first, one after a processor access
		setup(0, 20'h00E00, 20'h00F00, 16'h0, 5'h05);
		setup(1, 20'h00E10, 20'h00F10, 16'h0, 5'h05);
		unit(2'h3, 20'h00E00, 20'h00F00, 1, 1, 1'b0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			chk(32'(bus_hold), 32'h0);
		end
		pulse_done();
		unit(2'h0, 20'h00E10, 20'h00F10, 1, 1, 1'b1);
		rd_chk(OFF_STAT, 32'h0);
		report_and_stop();
	end
endmodule
